/* pkg/qio_pkg.sv */
// Constants and carrier types for the four-pin chip-select port.
package qio_pkg;

	// ----------------------------------------------------------------
	// Special function register offsets.
	// ----------------------------------------------------------------
	localparam logic [7:0] QIO_ADDR_DATA = 8'he8;
	localparam logic [7:0] QIO_ADDR_MODE_A = 8'ha2;
	localparam logic [7:0] QIO_ADDR_MODE_B = 8'ha3;
	localparam logic [7:0] QIO_ADDR_POLARITY = 8'hae;
	localparam logic [7:0] QIO_ADDR_BASE_LOW0 = 8'ha4;
	localparam logic [7:0] QIO_ADDR_BASE_HIGH0 = 8'ha5;
	localparam logic [7:0] QIO_ADDR_STEP = 8'h02;

	// ----------------------------------------------------------------
	// Field positions and reset values.
	// ----------------------------------------------------------------
	localparam int QIO_PINS = 4;
	localparam int QIO_FIELD_W = 4;
	localparam int QIO_MODE_LSB = 2;
	localparam int QIO_INV_LSB = 4;
	localparam int QIO_IRQ3_PIN = 2;
	localparam int QIO_IRQ2_PIN = 3;
	localparam logic [3:0] QIO_DATA_RESET = 4'hf;
	localparam logic [7:0] QIO_CTRL_RESET = 8'h00;
	localparam logic [15:0] QIO_BASE_RESET = 16'h0000;

	// Operating mode of one pin.
	typedef enum logic [1:0] {
		QIO_MODE_GPIO = 2'h0,
		QIO_MODE_RD = 2'h1,
		QIO_MODE_WR = 2'h2,
		QIO_MODE_RDWR = 2'h3
	} qio_mode_t;

	// Special function register access from the core.
	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} qio_sfr_t;

	// External memory cycle seen by the core, strobes active low.
	typedef struct packed {
		logic [15:0] addr;
		logic rd_n;
		logic wr_n;
	} qio_xbus_t;

endpackage : qio_pkg

/* logic/qio_sync.sv */
// Two-flop synchroniser for pin levels entering the core clock domain.
`timescale 1ns/1ps
module qio_sync #(
	parameter int WIDTH = 4
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic rstn,
	// Asynchronous levels and their synchronised copies.
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_reg;

	// The first stage feeds only the second; nothing else looks at it.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			meta_reg <= '1;
			sync_out <= '1;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule : qio_sync

/* logic/qio_port.sv */
// Four-pin port with general I/O and address-decoded chip-select strobes.
//
// What this block does
// - Four-pin port data at fixed address, per-pin config.
// - Four modes per pin from two mode registers.
// - Mode zero: quasi-bidirectional I/O driving latched data.
// - Mode zero pins 2, 3 feed interrupts three, two.
// - Mode one: read strobe on matching address.
// - Mode two: write strobe on matching address.
// - Mode three: strobe on read or write match.
// - Per-pin 16-bit base from high and low bytes.
// - Low address lines maskable from the comparison.
// - Per-pin invert bit flips strobe polarity; pin0 bit4.
// - External write in range strobes for whole access.
// - Data writes reach only general I/O pins.
`timescale 1ns/1ps
module qio_port (
	// Clock and reset.
	input wire logic clock,
	input wire logic rstn,
	// Special function register access.
	input wire qio_pkg::qio_sfr_t sfr,
	output logic [7:0] sfr_rdata,
	// External memory cycle of the core.
	input wire qio_pkg::qio_xbus_t xbus,
	// Interrupt enables from the interrupt controller.
	input wire logic ext_irq_two_en,
	input wire logic ext_irq_three_en,
	// Port pins.
	input wire logic [3:0] pin_in,
	output logic [3:0] pin_out,
	output logic [3:0] pin_oe,
	// Interrupt request levels, active low as on the pins.
	output logic ext_irq_two_n,
	output logic ext_irq_three_n
);

	// ----------------------------------------------------------------
	// Register state.
	// ----------------------------------------------------------------
	logic [3:0] data_reg;
	logic [3:0] data_next;
	logic [7:0] mode_a_reg;
	logic [7:0] mode_b_reg;
	logic [7:0] polarity_reg;
	logic [15:0] base_reg [qio_pkg::QIO_PINS];
	logic [3:0] pin_sync;
	logic [3:0] gpio_sel;
	logic [3:0] strobe_act;
	logic [15:0] mode_word;
	logic hit_data;
	logic hit_mode_a;
	logic hit_mode_b;
	logic hit_polarity;
	logic [3:0] hit_low;
	logic [3:0] hit_high;
	logic [7:0] rd_mux;
	logic [7:0] rd_base;
	logic xrd;
	logic xwr;

	// Pin levels enter through two flops before any logic reads them.
	qio_sync #(.WIDTH(4)) u_sync (
		.clock(clock),
		.rstn(rstn),
		.async_in(pin_in),
		.sync_out(pin_sync)
	);

	// ----------------------------------------------------------------
	// Address decode.
	// ----------------------------------------------------------------
	assign hit_data = (sfr.addr == qio_pkg::QIO_ADDR_DATA);
	assign hit_mode_a = (sfr.addr == qio_pkg::QIO_ADDR_MODE_A);
	assign hit_mode_b = (sfr.addr == qio_pkg::QIO_ADDR_MODE_B);
	assign hit_polarity = (sfr.addr == qio_pkg::QIO_ADDR_POLARITY);
	assign mode_word = {mode_b_reg, mode_a_reg};
	assign xrd = ~xbus.rd_n;
	assign xwr = ~xbus.wr_n;

	// ----------------------------------------------------------------
	// Per-pin mode, comparator and strobe.
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < qio_pkg::QIO_PINS; gi++) begin : g_pin
			localparam logic [7:0] OFS = 8'(gi) * qio_pkg::QIO_ADDR_STEP;
			wire [3:0] field = mode_word[gi*qio_pkg::QIO_FIELD_W +: qio_pkg::QIO_FIELD_W];
			wire qio_pkg::qio_mode_t mode = qio_pkg::qio_mode_t'(field[3:2]);
			wire [1:0] mask_code = field[1:0];
			// Masked low lines respond to 1, 2, 4 or 8 consecutive addresses.
			wire [15:0] care = (mask_code == 2'h0) ? 16'hffff :
				(mask_code == 2'h1) ? 16'hfffe :
				(mask_code == 2'h2) ? 16'hfffc : 16'hfff8;
			wire match = ((xbus.addr ^ base_reg[gi]) & care) == 16'h0000;
			wire rd_en = (mode == qio_pkg::QIO_MODE_RD) || (mode == qio_pkg::QIO_MODE_RDWR);
			wire wr_en = (mode == qio_pkg::QIO_MODE_WR) || (mode == qio_pkg::QIO_MODE_RDWR);
			// Strobe follows the core strobe for as long as it stays low.
			assign strobe_act[gi] = match & ((rd_en & xrd) | (wr_en & xwr));
			assign gpio_sel[gi] = (mode == qio_pkg::QIO_MODE_GPIO);
			assign hit_low[gi] = (sfr.addr == qio_pkg::QIO_ADDR_BASE_LOW0 + OFS);
			assign hit_high[gi] = (sfr.addr == qio_pkg::QIO_ADDR_BASE_HIGH0 + OFS);

			// Base comparator value loaded a byte at a time.
			always_ff @(posedge clock or negedge rstn) begin
				if (!rstn) begin
					base_reg[gi] <= qio_pkg::QIO_BASE_RESET;
				end else if (sfr.wr && hit_low[gi]) begin
					base_reg[gi][7:0] <= sfr.wdata;
				end else if (sfr.wr && hit_high[gi]) begin
					base_reg[gi][15:8] <= sfr.wdata;
				end
			end

			// Pin drive: strobe pins drive both levels, I/O pins only pull low.
			always_ff @(posedge clock or negedge rstn) begin
				if (!rstn) begin
					pin_out[gi] <= 1'b1;
					pin_oe[gi] <= 1'b0;
				end else if (gpio_sel[gi]) begin
					pin_out[gi] <= data_reg[gi];
					pin_oe[gi] <= ~data_reg[gi];
				end else begin
					// Idle level high unless inverted, so the strobe is active low.
					pin_out[gi] <= ~strobe_act[gi] ^ polarity_reg[qio_pkg::QIO_INV_LSB + gi];
					pin_oe[gi] <= 1'b1;
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Data latch: only general I/O bits take a write.
	// ----------------------------------------------------------------
	assign data_next = (sfr.wr && hit_data) ?
		((sfr.wdata[3:0] & gpio_sel) | (data_reg & ~gpio_sel)) : data_reg;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			data_reg <= qio_pkg::QIO_DATA_RESET;
		end else begin
			data_reg <= data_next;
		end
	end

	// Mode and polarity control registers.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			mode_a_reg <= qio_pkg::QIO_CTRL_RESET;
			mode_b_reg <= qio_pkg::QIO_CTRL_RESET;
			polarity_reg <= qio_pkg::QIO_CTRL_RESET;
		end else begin
			if (sfr.wr && hit_mode_a) begin
				mode_a_reg <= sfr.wdata;
			end
			if (sfr.wr && hit_mode_b) begin
				mode_b_reg <= sfr.wdata;
			end
			if (sfr.wr && hit_polarity) begin
				polarity_reg <= sfr.wdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// Read path and interrupt inputs.
	// ----------------------------------------------------------------
	// I/O pins read the pin level; strobe pins read back the latch.
	assign rd_base = hit_low[0] ? base_reg[0][7:0] : hit_high[0] ? base_reg[0][15:8] :
		hit_low[1] ? base_reg[1][7:0] : hit_high[1] ? base_reg[1][15:8] :
		hit_low[2] ? base_reg[2][7:0] : hit_high[2] ? base_reg[2][15:8] :
		hit_low[3] ? base_reg[3][7:0] : hit_high[3] ? base_reg[3][15:8] : 8'h00;
	assign rd_mux = hit_data ? {4'h0, (pin_sync & gpio_sel) | (data_reg & ~gpio_sel)} :
		hit_mode_a ? mode_a_reg :
		hit_mode_b ? mode_b_reg :
		hit_polarity ? polarity_reg : rd_base;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sfr_rdata <= 8'h00;
			ext_irq_two_n <= 1'b1;
			ext_irq_three_n <= 1'b1;
		end else begin
			sfr_rdata <= sfr.rd ? rd_mux : 8'h00;
			// Interrupt inputs are only live on I/O pins that have them enabled.
			ext_irq_three_n <= ~(ext_irq_three_en && gpio_sel[qio_pkg::QIO_IRQ3_PIN] &&
				!pin_sync[qio_pkg::QIO_IRQ3_PIN]);
			ext_irq_two_n <= ~(ext_irq_two_en && gpio_sel[qio_pkg::QIO_IRQ2_PIN] &&
				!pin_sync[qio_pkg::QIO_IRQ2_PIN]);
		end
	end

endmodule : qio_port

/* tb/qio_port_properties.sv */
// Port-level checks for the four-pin chip-select port.
`timescale 1ns/1ps
module qio_port_properties (
	// Clock and reset.
	input wire logic clock,
	input wire logic rstn,
	// Register and external bus.
	input wire qio_pkg::qio_sfr_t sfr,
	input wire logic [7:0] sfr_rdata,
	input wire qio_pkg::qio_xbus_t xbus,
	// Pins and interrupts.
	input wire logic ext_irq_two_en,
	input wire logic ext_irq_three_en,
	input wire logic [3:0] pin_in,
	input wire logic [3:0] pin_out,
	input wire logic [3:0] pin_oe,
	input wire logic ext_irq_two_n,
	input wire logic ext_irq_three_n
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	// Read data is a one-cycle answer, so a quiet bus must read as zero.
	a_rdata_quiet: assert property (!$past(sfr.rd) |-> sfr_rdata == 8'h00)
		else $error("read data without a read");
	a_unmapped_zero: assert property (sfr.rd && !(sfr.addr inside {8'he8, [8'ha2:8'hab],
		8'hae}) |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
	a_data_upper: assert property (sfr.rd && sfr.addr == 8'he8 |=> sfr_rdata[7:4] == 4'h0)
		else $error("upper data bits not zero");
	// A pin left undriven must rest high, or the pull-up could never win.
	a_oe_quasi: assert property (&(pin_out | pin_oe)) else $error("undriven pin low");
	a_pins_hold: assert property (!sfr.wr && !$past(sfr.wr) && $stable(xbus) |=>
		$stable(pin_out) && $stable(pin_oe)) else $error("pins moved without cause");
	a_irq_two_cause: assert property (!ext_irq_two_n |-> $past(ext_irq_two_en) &&
		(!$past(pin_in[3], 3) || !$past(rstn, 3))) else $error("irq two without low pin");
	a_irq_three_cause: assert property (!ext_irq_three_n |-> $past(ext_irq_three_en) &&
		(!$past(pin_in[2], 3) || !$past(rstn, 3))) else $error("irq three without low pin");
	a_irq_three_gate: assert property (!ext_irq_three_en |=> ext_irq_three_n)
		else $error("irq three while disabled");
	c_irq_two: cover property (!ext_irq_two_n);
	c_strobe: cover property ($changed(pin_out) && !$past(sfr.wr));
	c_read: cover property (sfr_rdata != 8'h00);
endmodule : qio_port_properties

bind qio_port qio_port_properties u_qio_port_properties (.clock(clock), .rstn(rstn), .sfr(sfr),
	.sfr_rdata(sfr_rdata), .xbus(xbus), .ext_irq_two_en(ext_irq_two_en),
	.ext_irq_three_en(ext_irq_three_en), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
	.ext_irq_two_n(ext_irq_two_n), .ext_irq_three_n(ext_irq_three_n));

/* tb/qio_periph.sv */
// Far side of the pins: pull-ups and a peripheral that can ground a line.
`timescale 1ns/1ps
module qio_periph (
	// Drive from the port.
	input wire logic [3:0] pin_out,
	input wire logic [3:0] pin_oe,
	// Lines grounded by the peripheral.
	input wire logic [3:0] ext_low,
	// Resolved levels.
	output logic [3:0] pin_in
);
	// Wired-AND with pull-ups, so a released line never keeps its last value.
	assign pin_in = ~((pin_oe & ~pin_out) | ext_low);
endmodule : qio_periph

/* tb/tb_top.sv */
// Self-checking bench for the four-pin chip-select port.
`timescale 1ns/1ps
module tb_top;
	logic clock, rstn, irq2_en, irq3_en, irq2_n, irq3_n;
	qio_pkg::qio_sfr_t sfr;
	qio_pkg::qio_xbus_t xbus;
	logic [7:0] sfr_rdata;
	logic [3:0] pin_in, pin_out, pin_oe, ext_low;
	int fail_count = 0;
	int tests_run = 0;
	qio_port u_qio_port (.clock(clock), .rstn(rstn), .sfr(sfr), .sfr_rdata(sfr_rdata), .xbus(xbus),
		.ext_irq_two_en(irq2_en), .ext_irq_three_en(irq3_en), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .ext_irq_two_n(irq2_n), .ext_irq_three_n(irq3_n));
	qio_periph u_qio_periph (.pin_out(pin_out), .pin_oe(pin_oe), .ext_low(ext_low), .pin_in(pin_in));
	// --------
	// Tasks.
	// --------
	task automatic stop_test;
		if (fail_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// One register cycle; read data stands only one cycle, so it is taken right after.
	task automatic sop(input logic [7:0] a, input logic w, input logic [7:0] d);
		@(posedge clock);
		sfr <= '{addr: a, wr: w, rd: !w, wdata: d};
		@(posedge clock);
		sfr <= '0;
		#1;
	endtask : sop
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		sop(a, 1'b0, 8'h00);
		chk(sfr_rdata, exp);
	endtask : rd
	// Strobe lags the core cycle by one clock, both rising and falling.
	task automatic xop(input logic [15:0] a, input logic r, input logic w, input logic [3:0] on,
		input logic [3:0] off);
		@(posedge clock);
		xbus <= '{addr: a, rd_n: r, wr_n: w};
		repeat (3) @(posedge clock);
		#1 chk({4'h0, pin_out}, {4'h0, on});
		@(posedge clock);
		xbus <= '{addr: a, rd_n: 1'b1, wr_n: 1'b1};
		repeat (2) @(posedge clock);
		#1 chk({4'h0, pin_out}, {4'h0, off});
	endtask : xop
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	initial begin
		repeat (2000) @(posedge clock);
		fail_count++;
		stop_test();
	end
	initial begin
		rstn = 1'b0;
		sfr = '0;
		xbus = '{addr: 16'h0000, rd_n: 1'b1, wr_n: 1'b1};
		{irq2_en, irq3_en, ext_low} = 6'h00;
		repeat (16) @(posedge clock);
		rstn <= 1'b1;
		rd(8'he8, 8'h0f);
		rd(8'hb0, 8'h00);
		sop(8'ha5, 1'b1, 8'h12);
		sop(8'ha4, 1'b1, 8'h34);
		sop(8'ha2, 1'b1, 8'h0a);
		sop(8'he8, 1'b1, 8'h00);
		rd(8'ha2, 8'h0a);
		xop(16'h1237, 1'b1, 1'b0, 4'h0, 4'h1);
		xop(16'h1238, 1'b1, 1'b0, 4'h1, 4'h1);
		xop(16'h1234, 1'b0, 1'b1, 4'h1, 4'h1);
		sop(8'hae, 1'b1, 8'h10);
		xop(16'h1235, 1'b1, 1'b0, 4'h1, 4'h0);
		sop(8'ha2, 1'b1, 8'h04);
		xop(16'h1234, 1'b0, 1'b1, 4'h1, 4'h0);
		xop(16'h1235, 1'b0, 1'b1, 4'h0, 4'h0);
		xop(16'h1234, 1'b1, 1'b0, 4'h0, 4'h0);
		sop(8'ha2, 1'b1, 8'h0d);
		xop(16'h1235, 1'b0, 1'b1, 4'h1, 4'h0);
		xop(16'h1235, 1'b1, 1'b0, 4'h1, 4'h0);
		xop(16'h1236, 1'b1, 1'b0, 4'h0, 4'h0);
		sop(8'ha2, 1'b1, 8'h0b);
		xop(16'h1230, 1'b1, 1'b0, 4'h1, 4'h0);
		xop(16'h1238, 1'b1, 1'b0, 4'h0, 4'h0);
		sop(8'he8, 1'b1, 8'h0f);
		@(posedge clock);
		irq2_en <= 1'b1;
		irq3_en <= 1'b1;
		ext_low <= 4'hc;
		repeat (4) @(posedge clock);
		#1 chk({6'h00, irq2_n, irq3_n}, 8'h00);
		rd(8'he8, 8'h03);
		@(posedge clock);
		irq3_en <= 1'b0;
		repeat (2) @(posedge clock);
		#1 chk({6'h00, irq2_n, irq3_n}, 8'h01);
		stop_test();
	end
endmodule : tb_top
